// *** bench/timer2_ctrl_flags_irq_tb.sv ***
// Purpose: register-level test of the timer block
// Assumes: 100 ns clock, reset held five cycles
// Notes:   prescaled counts are checked within a window of three
`timescale 1ns/100ps
`include "tmr2_defines.vh"
module timer2_ctrl_flags_irq_tb;
    localparam [2:0] a_ca = `TMR2_ADDR_CTRL_A;
    localparam [2:0] a_cb = `TMR2_ADDR_CTRL_B;
    localparam [2:0] a_cn = `TMR2_ADDR_COUNT;
    localparam [2:0] a_fl = `TMR2_ADDR_FLAGS;
    logic       ref_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       global_irq_en_i = 1'b0;
    logic [2:0] vector_ack_i = 3'h0;
    logic [7:0] rdata_o, d;
    logic [2:0] irq_req_o;
    logic       wave_out_a_o, wave_out_b_o, wave_oe_a_o, wave_oe_b_o;
    int error_cnt = 0;
    int checks = 0;
    // code 0 stands still, so its divisor only has to give zero
    int divs [8] = '{4096, 1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] fa [5] = '{8'hf2, 8'ha0, 8'h50, 8'hf3, 8'hf1};
    logic [7:0] fb [5] = '{8'hc0, 8'h80, 8'h40, 8'hc0, 8'hc0};
    logic [7:0] fe [5] = '{8'h03, 8'h02, 8'h00, 8'h00, 8'h00};
    // clock
    always #50 ref_clk_i = ~ref_clk_i;
    tmr2_ctrl i_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .global_irq_en_i(global_irq_en_i), .vector_ack_i(vector_ack_i),
        .irq_req_o(irq_req_o), .wave_out_a_o(wave_out_a_o),
        .wave_out_b_o(wave_out_b_o), .wave_oe_a_o(wave_oe_a_o),
        .wave_oe_b_o(wave_oe_b_o));
    // one-cycle register write
    task wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle
    task rd_reg(input logic [2:0] a);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // count may run up to three ticks past the ideal value
    task chk_near(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if ((8'(g - e) <= 8'h03) !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t count %h near %h", $time, g, e);
        end
    endtask
    // run the counter with a clock select for n cycles, then stop
    task run(input logic [2:0] s, input int n);
        wr_reg(a_cb, {5'h00, s});
        repeat (n) @(posedge ref_clk_i);
        wr_reg(a_cb, 8'h00);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #3000000;
        error_cnt++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd_reg(a_cb);
        chk(d, 8'h00);
        rd_reg(3'h7);
        chk(d, 8'h00);
        wr_reg(a_cb, 8'hf8);
        rd_reg(a_cb);
        chk(d, 8'h08);
        wr_reg(`TMR2_ADDR_MASK, 8'hff);
        rd_reg(`TMR2_ADDR_MASK);
        chk(d, 8'h07);
        wr_reg(`TMR2_ADDR_CMP_A, 8'h5a);
        wr_reg(`TMR2_ADDR_CMP_B, 8'ha5);
        wr_reg(a_cn, 8'h3c);
        rd_reg(`TMR2_ADDR_CMP_A);
        chk(d, 8'h5a);
        rd_reg(`TMR2_ADDR_CMP_B);
        chk(d, 8'ha5);
        rd_reg(a_cn);
        chk(d, 8'h3c);
        $display("register test done");
        for (int s = 0; s < 8; s++) begin
            wr_reg(a_cn, 8'h00);
            run(s[2:0], 1000);
            rd_reg(a_cn);
            chk_near(d, 8'(1000 / divs[s]));
        end
        $display("prescaler test done");
        wr_reg(`TMR2_ADDR_CMP_A, 8'h10);
        wr_reg(`TMR2_ADDR_CMP_B, 8'h80);
        wr_reg(`TMR2_ADDR_MASK, 8'h02);
        // prescaler runs left matches and overflows behind
        wr_reg(a_fl, 8'h07);
        rd_reg(a_fl);
        chk(d, 8'h00);
        global_irq_en_i <= 1'b1;
        wr_reg(a_cn, 8'h08);
        run(3'h1, 20);
        rd_reg(a_fl);
        chk(d, 8'h02);
        chk({5'h00, irq_req_o}, 8'h02);
        @(posedge ref_clk_i);
        global_irq_en_i <= 1'b0;
        #1 chk({5'h00, irq_req_o}, 8'h00);
        wr_reg(a_fl, 8'h05);
        rd_reg(a_fl);
        chk(d, 8'h02);
        @(posedge ref_clk_i);
        vector_ack_i <= 3'h2;
        @(posedge ref_clk_i);
        vector_ack_i <= 3'h0;
        rd_reg(a_fl);
        chk(d, 8'h00);
        wr_reg(a_cn, 8'h78);
        run(3'h1, 20);
        rd_reg(a_fl);
        chk(d, 8'h04);
        wr_reg(a_fl, 8'h04);
        wr_reg(a_cn, 8'hf8);
        run(3'h1, 12);
        rd_reg(a_fl);
        chk(d, 8'h01);
        wr_reg(a_fl, 8'h07);
        wr_reg(a_cn, 8'h40);
        wr_reg(a_cb, 8'h01);
        wr_reg(a_cn, 8'h10);
        wr_reg(a_cb, 8'h00);
        rd_reg(a_fl);
        chk(d, 8'h00);
        $display("flag test done");
        wr_reg(a_cn, 8'h33);
        for (int i = 0; i < 5; i++) begin
            wr_reg(a_ca, fa[i]);
            wr_reg(a_cb, fb[i]);
            #1 chk({6'h00, wave_out_b_o, wave_out_a_o}, fe[i]);
        end
        rd_reg(a_cn);
        chk(d, 8'h33);
        rd_reg(a_fl);
        chk(d, 8'h00);
        $display("force test done");
        finish_test;
    end
endmodule

// *** bench/tmr2_ctrl_props.sv ***
// Purpose: port checks for the timer register block
// Assumes: one clock, synchronous active-high reset
// Notes:   a shadow of control a tracks the written modes
`timescale 1ns/100ps
`include "tmr2_defines.vh"
module tmr2_ctrl_props (
    // clock, reset and register port
    input logic       ref_clk_i,
    input logic       sys_rst_i,
    input logic [2:0] addr_i,
    input logic [7:0] wdata_i,
    input logic       wr_i,
    input logic       rd_i,
    input logic [7:0] rdata_o,
    // cpu and waveform side
    input logic       global_irq_en_i,
    input logic [2:0] vector_ack_i,
    input logic [2:0] irq_req_o,
    input logic       wave_out_a_o,
    input logic       wave_out_b_o,
    input logic       wave_oe_a_o,
    input logic       wave_oe_b_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] shd_a;
    wire rd_b = rd_i && (addr_i == `TMR2_ADDR_CTRL_B);
    wire wr_b = wr_i && (addr_i == `TMR2_ADDR_CTRL_B);
    wire wr_a = wr_i && (addr_i == `TMR2_ADDR_CTRL_A);
    wire mk = addr_i == `TMR2_ADDR_MASK;
    // shadow of control a, for the force check
    always @(posedge ref_clk_i) begin
        if (sys_rst_i)
            shd_a <= 8'h00;
        else if (wr_a)
            shd_a <= wdata_i;
    end
    property p_frd; rd_b |=> rdata_o[7:6] == 2'b00; endproperty
    a_frd: assert property (p_frd)
        else $error("force bits read back nonzero");
    property p_res; rd_b |=> rdata_o[5:4] == 2'b00; endproperty
    a_res: assert property (p_res)
        else $error("reserved bits read back nonzero");
    property p_mrd; rd_i && mk |=> rdata_o[7:3] == 5'h00; endproperty
    a_mrd: assert property (p_mrd)
        else $error("mask upper bits read back nonzero");
    property p_glb; !global_irq_en_i |-> irq_req_o == 3'h0; endproperty
    a_glb: assert property (p_glb)
        else $error("request without global enable");
    property p_msk; wr_i && mk && !wdata_i[0] |=> !irq_req_o[0]; endproperty
    a_msk: assert property (p_msk)
        else $error("overflow request while masked");
    property p_oea;
        wr_a |=> wave_oe_a_o == ($past(wdata_i[7:6]) != 2'b00);
    endproperty
    a_oea: assert property (p_oea)
        else $error("channel a pin override wrong");
    property p_oeb;
        wr_a |=> wave_oe_b_o == ($past(wdata_i[5:4]) != 2'b00);
    endproperty
    a_oeb: assert property (p_oeb)
        else $error("channel b pin override wrong");
    property p_fca;
        wr_b && wdata_i[7] && !shd_a[0] && shd_a[7:6] == 2'b11
            |=> wave_out_a_o;
    endproperty
    a_fca: assert property (p_fca)
        else $error("forced set on channel a missing");
endmodule

bind tmr2_ctrl tmr2_ctrl_props i_props (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .global_irq_en_i(global_irq_en_i), .vector_ack_i(vector_ack_i),
    .irq_req_o(irq_req_o), .wave_out_a_o(wave_out_a_o),
    .wave_out_b_o(wave_out_b_o), .wave_oe_a_o(wave_oe_a_o),
    .wave_oe_b_o(wave_oe_b_o));

// *** design/tmr2_ctrl.v ***
// Purpose: 8-bit timer with two compare channels, prescaler, flags, masks
// Assumes: one clock; prescaler source is the module clock
// Notes:   ctrl_a holds out_mode_a [7:6], out_mode_b [5:4], wave mode [1:0]
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "tmr2_defines.vh"

// How it works
// - force strobes act only in non-pwm modes (0, 2, 4 and 6)
// - a force strobe applies that channel's output-mode action at once
// - a forced compare sets no flag and never clears the counter
// - force bits read back as zero
// - ctrl_b: force a/b at 7/6, mode upper bit 3, clock select 2:0
// - clock select 000 stops the counter
// - ctrl_b bits 5:4 read zero
// - count register is readable and writable
// - a count write blocks compare matches on the next tick
// - compare a matches the count for flag and waveform a
// - compare b matches the count for flag and waveform b
// - mask: cmp b en bit 2, cmp a en bit 1, ovf en bit 0
// - cmp b flag bit 2 set on match with compare b
// - cmp a flag bit 1 set on match with compare a
// - ovf flag set on overflow, at top in mode 7, or at bottom turn in phase pwm modes
// - a vector acknowledge clears its flag
// - writing one clears a flag, zero leaves it
// - interrupt asked when global enable, mask and flag all set
// - upper mode bit with two lower bits picks sequence and top
// - output mode decides pin override and match action
module tmr2_ctrl (
    // clock and reset
    input  wire       ref_clk_i,
    input  wire       sys_rst_i,
    // register port
    input  wire [2:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    // cpu side
    input  wire       global_irq_en_i,
    input  wire [2:0] vector_ack_i,
    output wire [2:0] irq_req_o,
    // waveform outputs
    output reg        wave_out_a_o,
    output reg        wave_out_b_o,
    output wire       wave_oe_a_o,
    output wire       wave_oe_b_o
);

    reg  [7:0] ctrl_a;
    reg  [3:0] ctrl_b;          // wave_mode_upper_bit and clk_sel_field
    reg  [7:0] count_value;
    reg  [7:0] compare_value_a;
    reg  [7:0] compare_value_b;
    reg  [2:0] irq_mask;
    reg  [2:0] irq_flags;
    reg  [9:0] presc;
    reg        count_down;
    reg        block_match;
    reg        tick;
    reg  [7:0] top;
    reg  [7:0] next_count;
    reg        next_down;
    wire [2:0] wave_mode_field;
    wire [2:0] clk_sel_field;
    wire       pwm_mode;
    wire       fast_pwm;
    wire       phase_pwm;
    wire       clear_on_match_mode;
    wire       wr_ctrl_b;
    wire       wr_count;
    wire       force_a;
    wire       force_b;
    wire       match_a;
    wire       match_b;
    wire       at_top;
    wire       ovf_ev;
    wire       wr_ctrl_a;
    wire       wr_cmp_a;
    wire       wr_cmp_b;
    wire       wr_mask;
    wire       wr_flags;
    wire [2:0] flag_set;
    wire [2:0] flag_clr_sw;
    wire [2:0] flag_clr;
    wire       top_act;
    reg        next_wave_a;
    reg        next_wave_b;
    reg  [7:0] next_rdata;

    // mode decoding
    assign wave_mode_field = {ctrl_b[3], ctrl_a[1:0]};
    assign clk_sel_field   = ctrl_b[2:0];
    assign fast_pwm  = (wave_mode_field[1:0] == 2'b11);
    assign phase_pwm = (wave_mode_field[1:0] == 2'b01);
    assign pwm_mode  = fast_pwm | phase_pwm;
    assign clear_on_match_mode = (wave_mode_field == 3'h2);

    // write strobes per register, one shared decoder
    assign wr_ctrl_a = reg_hit(wr_i, addr_i, `TMR2_ADDR_CTRL_A);
    assign wr_ctrl_b = reg_hit(wr_i, addr_i, `TMR2_ADDR_CTRL_B);
    assign wr_count  = reg_hit(wr_i, addr_i, `TMR2_ADDR_COUNT);
    assign wr_cmp_a  = reg_hit(wr_i, addr_i, `TMR2_ADDR_CMP_A);
    assign wr_cmp_b  = reg_hit(wr_i, addr_i, `TMR2_ADDR_CMP_B);
    assign wr_mask   = reg_hit(wr_i, addr_i, `TMR2_ADDR_MASK);
    assign wr_flags  = reg_hit(wr_i, addr_i, `TMR2_ADDR_FLAGS);

    // force strobes, gated off in pwm modes
    assign force_a = wr_ctrl_b & wdata_i[`TMR2_BIT_FORCE_A] & ~pwm_mode;
    assign force_b = wr_ctrl_b & wdata_i[`TMR2_BIT_FORCE_B] & ~pwm_mode;

    // top value by mode
    always @* begin
        if (wave_mode_field[2] || clear_on_match_mode) begin
            top = compare_value_a;
        end else begin
            top = `TMR2_TOP_MAX;
        end
    end

    // prescaler tick select
    always @* begin
        case (clk_sel_field)
            3'h1:    tick = 1'b1;
            3'h2:    tick = (presc[2:0] == 3'h7);
            3'h3:    tick = (presc[4:0] == 5'h1f);
            3'h4:    tick = (presc[5:0] == 6'h3f);
            3'h5:    tick = (presc[6:0] == 7'h7f);
            3'h6:    tick = (presc[7:0] == 8'hff);
            3'h7:    tick = (presc == 10'h3ff);
            default: tick = 1'b0;
        endcase
    end

    // prescaler counter, free running while a source is selected
    always @(posedge ref_clk_i) begin
        if (sys_rst_i || clk_sel_field == 3'h0) begin
            presc <= 10'h000;
        end else begin
            presc <= presc + 10'h001;
        end
    end

    // compare matches, suppressed one tick after a count write
    assign match_a = tick & ~block_match & (count_value == compare_value_a);
    assign match_b = tick & ~block_match & (count_value == compare_value_b);
    assign at_top  = (count_value == top);

    // next count value by sequence
    always @* begin
        next_count = count_value + 8'h01;
        next_down  = count_down;
        if (phase_pwm) begin
            if (!count_down && at_top) begin
                next_down  = 1'b1;
                next_count = count_value - 8'h01;
            end else if (count_down && count_value == `TMR2_BOTTOM) begin
                next_down  = 1'b0;
                next_count = count_value + 8'h01;
            end else if (count_down) begin
                next_count = count_value - 8'h01;
            end
        end else if (at_top && top != `TMR2_TOP_MAX) begin
            next_count = `TMR2_BOTTOM;     // clear-on-match, variable top
        end
    end

    // overflow event
    assign ovf_ev = tick & (phase_pwm ?
                    (count_down && count_value == `TMR2_BOTTOM) :
                    (wave_mode_field == 3'h7 ? at_top :
                     count_value == `TMR2_TOP_MAX));

    // counter, direction and match blocking
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            count_value <= `TMR2_COUNT_RST;
            count_down  <= 1'b0;
            block_match <= 1'b0;
        end else if (wr_count) begin
            count_value <= wdata_i;
            block_match <= 1'b1;
        end else if (tick) begin
            count_value <= next_count;
            count_down  <= next_down;
            block_match <= 1'b0;
        end
    end

    // control a: output modes and lower mode bits, bits 3:2 kept zero
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl_a <= `TMR2_CTRL_A_RST;
        end else if (wr_ctrl_a) begin
            ctrl_a <= {wdata_i[7:4], 2'b00, wdata_i[1:0]};
        end
    end

    // control b: only mode upper bit and clock select are stored
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl_b <= `TMR2_CTRL_B_RST;
        end else if (wr_ctrl_b) begin
            ctrl_b <= wdata_i[3:0];
        end
    end

    // compare a register
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            compare_value_a <= `TMR2_CMP_RST;
        end else if (wr_cmp_a) begin
            compare_value_a <= wdata_i;
        end
    end

    // compare b register
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            compare_value_b <= `TMR2_CMP_RST;
        end else if (wr_cmp_b) begin
            compare_value_b <= wdata_i;
        end
    end

    // interrupt mask, upper bits not stored
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_mask <= `TMR2_MASK_RST;
        end else if (wr_mask) begin
            irq_mask <= wdata_i[2:0];
        end
    end

    // flag sources; a forced compare is no match, so sets nothing
    assign flag_set    = {match_b, match_a, ovf_ev};
    assign flag_clr_sw = wr_flags ? wdata_i[2:0] : 3'h0;
    assign flag_clr    = flag_clr_sw | vector_ack_i;

    // flags: hardware set beats software or vector clear in one cycle
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_flags <= 3'h0;
        end else begin
            irq_flags <= (irq_flags & ~flag_clr) | flag_set;
        end
    end

    // interrupt requests
    assign irq_req_o = irq_flags & irq_mask & {3{global_irq_en_i}};

    // pin override when output mode is non-zero
    assign wave_oe_a_o = |ctrl_a[7:6];
    assign wave_oe_b_o = |ctrl_a[5:4];

    // fast pwm top action, taken only on a counting tick
    assign top_act = tick & at_top & fast_pwm;

    // next waveform levels; force uses the non-pwm action
    always @* begin
        next_wave_a = wave_out_a_o;
        next_wave_b = wave_out_b_o;
        if (!pwm_mode) begin
            if (match_a || force_a) begin
                next_wave_a = nonpwm_act(ctrl_a[7:6], wave_out_a_o);
            end
            if (match_b || force_b) begin
                next_wave_b = nonpwm_act(ctrl_a[5:4], wave_out_b_o);
            end
        end else begin
            if (match_a) begin
                next_wave_a = pwm_act(ctrl_a[7:6], wave_out_a_o);
            end else if (top_act && ctrl_a[7]) begin
                next_wave_a = ~ctrl_a[6];
            end
            if (match_b) begin
                next_wave_b = pwm_act(ctrl_a[5:4], wave_out_b_o);
            end else if (top_act && ctrl_a[5]) begin
                next_wave_b = ~ctrl_a[4];
            end
        end
    end

    // waveform registers
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wave_out_a_o <= 1'b0;
            wave_out_b_o <= 1'b0;
        end else begin
            wave_out_a_o <= next_wave_a;
            wave_out_b_o <= next_wave_b;
        end
    end

    // read mux; force and reserved bits read as zero
    always @* begin
        next_rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `TMR2_ADDR_CTRL_A: next_rdata = ctrl_a;
                `TMR2_ADDR_CTRL_B: next_rdata = {4'h0, ctrl_b};
                `TMR2_ADDR_COUNT:  next_rdata = count_value;
                `TMR2_ADDR_CMP_A:  next_rdata = compare_value_a;
                `TMR2_ADDR_CMP_B:  next_rdata = compare_value_b;
                `TMR2_ADDR_MASK:   next_rdata = {5'h00, irq_mask};
                `TMR2_ADDR_FLAGS:  next_rdata = {5'h00, irq_flags};
                default:           next_rdata = 8'h00;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // non-pwm match action: toggle, clear or set
    function nonpwm_act;
        input [1:0] mode;
        input       cur;
        begin
            case (mode)
                2'h1:    nonpwm_act = ~cur;
                2'h2:    nonpwm_act = 1'b0;
                2'h3:    nonpwm_act = 1'b1;
                default: nonpwm_act = cur;
            endcase
        end
    endfunction

    // pwm match action, reversed while counting down
    function pwm_act;
        input [1:0] mode;
        input       cur;
        begin
            case (mode)
                2'h2:    pwm_act = count_down;
                2'h3:    pwm_act = ~count_down;
                default: pwm_act = cur;
            endcase
        end
    endfunction

    // register strobe decode: strobe high at the given address
    function reg_hit;
        input       strobe;
        input [2:0] addr;
        input [2:0] target;
        begin
            reg_hit = strobe & (addr == target);
        end
    endfunction

endmodule

// *** design/tmr2_defines.vh ***
// Purpose: register offsets, field positions, reset values for the timer
// Assumes: 8-bit registers on a plain address/strobe port
// Notes:   offsets are local choices
`ifndef TMR2_DEFINES_VH
`define TMR2_DEFINES_VH
`define TMR2_ADDR_CTRL_A    3'h0
`define TMR2_ADDR_CTRL_B    3'h1
`define TMR2_ADDR_COUNT     3'h2
`define TMR2_ADDR_CMP_A     3'h3
`define TMR2_ADDR_CMP_B     3'h4
`define TMR2_ADDR_MASK      3'h5
`define TMR2_ADDR_FLAGS     3'h6
`define TMR2_BIT_FORCE_A    7
`define TMR2_BIT_FORCE_B    6
`define TMR2_BIT_MODE_UP    3
`define TMR2_CTRL_B_RST     4'h0
`define TMR2_CTRL_A_RST     8'h00
`define TMR2_MASK_RST       3'h0
`define TMR2_COUNT_RST      8'h00
`define TMR2_CMP_RST        8'h00
`define TMR2_TOP_MAX        8'hff
`define TMR2_BOTTOM         8'h00
`endif
